/* File: common/arc_pkg.sv */
// package: register map, field layout and reset values of the result block
package arc_pkg;
   // ************************************************************
   // register offsets (register index on the plain port)
   // ************************************************************
   localparam logic [3:0] OFS_RESULT_HIGH  = 4'h0;
   localparam logic [3:0] OFS_RESULT_LOW   = 4'h1;
   localparam logic [3:0] OFS_CMP_HIGH     = 4'h2;
   localparam logic [3:0] OFS_CMP_LOW      = 4'h3;
   localparam logic [3:0] OFS_CONFIG       = 4'h4;
   localparam logic [3:0] OFS_PIN_DISABLE  = 4'h5;
   localparam logic [3:0] OFS_CMP_CTRL     = 4'h6;
   localparam logic [3:0] OFS_STATUS       = 4'h7;
   // ************************************************************
   // configuration fields
   // ************************************************************
   localparam int CFG_LOW_POWER_BIT  = 7;
   localparam int CFG_DIV_LSB        = 5;
   localparam int CFG_LONG_SMP_BIT   = 4;
   localparam int CFG_WIDTH_LSB      = 2;
   localparam int CFG_CLKSEL_LSB     = 0;
   localparam logic [1:0] WIDTH_8    = 2'h0;
   localparam logic [1:0] WIDTH_10   = 2'h2;
   // compare control and status fields
   localparam int CTL_ENABLE_BIT     = 0;
   localparam int CTL_POLARITY_BIT   = 1;
   localparam int STS_COMPLETE_BIT   = 0;
   localparam int STS_FROZEN_BIT     = 1;
   localparam int STS_VALID_BIT      = 2;
   // reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
endpackage

/* File: verilog/arc_regs.sv */
// design: result, compare and configuration registers of the converter
//
// Function
// - result low holds bits 7:0 at 10-bit, whole result at 8-bit.
// - results load at completion unless compare enabled and not satisfied, or frozen at 10-bit.
// - 10-bit: reading result high freezes results until result low read.
// - completions during freeze are discarded, never transferred.
// - 8-bit: no freeze; every completion passing the compare updates result low.
// - after width change result low is invalid until next completion.
// - compare high holds upper two bits, compared in 10-bit mode.
// - 8-bit: compare high is ignored by compare logic.
// - compare low bits compared with result bits 7:0 in both widths.
// - config bit 7 selects high speed (0) or low power (1).
// - config bits 6:5 divide input clock by 1, 2, 4, 8.
// - config bit 4 selects short (0) or long (1) sample.
// - config bits 3:2: 00 8-bit, 10 10-bit; 01, 11 reserved.
// - config bits 1:0 pick bus, bus/2, alternate or internal clock.
// - pin disable bit n governs channel n pin, 1 removes port control.
// - disabled pin: output high-z, input reads zero, pullup off.
// - complete flag set only when compare true, or always if disabled, except during a 10-bit freeze.
// - polarity 0: less than true; 1: greater or equal true.
// - 8-bit: result high bits read zero.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module arc_regs #(
   parameter int CHANNELS = 8
) (
   input  wire logic                clock_i,
   input  wire logic                reset_i,
   input  wire logic [3:0]          addr_i,
   input  wire logic [7:0]          wdata_i,
   input  wire logic                write_i,
   input  wire logic                read_i,
   output logic      [7:0]          rdata_o,
   input  wire logic                done_i,
   input  wire logic [9:0]          conv_data_i,
   output logic                     low_power_o,
   output logic      [1:0]          clock_divide_o,
   output logic                     long_sample_o,
   output logic                     width_10bit_o,
   output logic      [1:0]          input_clock_select_o,
   output logic                     complete_o,
   input  wire logic                bus_clock_i,
   input  wire logic                alternate_clock_i,
   input  wire logic                internal_async_clock_i,
   output logic                     converter_clock_o,
   input  wire logic [CHANNELS-1:0] port_out_i,
   input  wire logic [CHANNELS-1:0] port_oe_i,
   input  wire logic [CHANNELS-1:0] port_pullup_i,
   input  wire logic [CHANNELS-1:0] pin_in_i,
   output logic      [CHANNELS-1:0] pin_out_o,
   output logic      [CHANNELS-1:0] pin_oe_o,
   output logic      [CHANNELS-1:0] pin_pullup_o,
   output logic      [CHANNELS-1:0] port_in_o
);
   // the pin-disable register is one byte wide
   initial begin
      if (CHANNELS != 8) $error("arc_regs: CHANNELS must be 8");
   end

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0]  result_low, next_result_low;
   logic [1:0]  result_top, next_result_top;
   logic [7:0]  compare_value_high, next_compare_value_high;
   logic [7:0]  compare_value_low, next_compare_value_low;
   logic [7:0]  converter_config, next_converter_config;
   logic [7:0]  analog_pin_disable_low, next_analog_pin_disable_low;
   logic        compare_enable, next_compare_enable;
   logic        compare_polarity, next_compare_polarity;
   logic        complete, next_complete;
   logic        frozen, next_frozen;
   logic        valid, next_valid;
   logic [7:0]  next_rdata;
   logic        wide;
   logic [9:0]  cmp_value, cmp_result;
   logic        cmp_less, cmp_true, accept;

   assign wide = (converter_config[3:2] == arc_pkg::WIDTH_10);

   // ************************************************************
   // compare logic
   // ************************************************************
   // 8-bit width ignores the high compare byte and the two top bits
   always_comb begin
      if (wide) begin
         cmp_value  = {compare_value_high[1:0], compare_value_low};
         cmp_result = conv_data_i;
      end else begin
         cmp_value  = {2'h0, compare_value_low};
         cmp_result = {2'h0, conv_data_i[7:0]};
      end
      cmp_less = (cmp_result < cmp_value);
      cmp_true = compare_polarity ? !cmp_less : cmp_less;
      // a frozen pair drops the completion entirely
      accept   = done_i && !(wide && frozen)
                 && (!compare_enable || cmp_true);
   end

   // ************************************************************
   // next-state for registers and read data
   // ************************************************************
   always_comb begin
      next_result_low             = result_low;
      next_result_top             = result_top;
      next_compare_value_high     = compare_value_high;
      next_compare_value_low      = compare_value_low;
      next_converter_config       = converter_config;
      next_analog_pin_disable_low = analog_pin_disable_low;
      next_compare_enable         = compare_enable;
      next_compare_polarity       = compare_polarity;
      next_complete               = complete;
      next_frozen                 = frozen;
      next_valid                  = valid;
      next_rdata                  = arc_pkg::RST_BYTE;
      // software side: reads and writes
      if (write_i) begin
         case (addr_i)
            arc_pkg::OFS_CMP_HIGH:    next_compare_value_high = wdata_i;
            arc_pkg::OFS_CMP_LOW:     next_compare_value_low  = wdata_i;
            arc_pkg::OFS_CONFIG: begin
               next_converter_config = wdata_i;
               if (wdata_i[3:2] != converter_config[3:2]) begin
                  next_valid  = 1'b0;
                  next_frozen = 1'b0;
               end
            end
            arc_pkg::OFS_PIN_DISABLE: next_analog_pin_disable_low = wdata_i;
            arc_pkg::OFS_CMP_CTRL: begin
               next_compare_enable   = wdata_i[arc_pkg::CTL_ENABLE_BIT];
               next_compare_polarity = wdata_i[arc_pkg::CTL_POLARITY_BIT];
            end
            default: ;
         endcase
      end
      if (read_i) begin
         case (addr_i)
            arc_pkg::OFS_RESULT_HIGH: begin
               next_rdata = wide ? {6'h0, result_top} : 8'h00;
               if (wide) next_frozen = 1'b1;
            end
            arc_pkg::OFS_RESULT_LOW: begin
               next_rdata    = result_low;
               next_frozen   = 1'b0;
               next_complete = 1'b0;
            end
            arc_pkg::OFS_CMP_HIGH:    next_rdata = compare_value_high;
            arc_pkg::OFS_CMP_LOW:     next_rdata = compare_value_low;
            arc_pkg::OFS_CONFIG:      next_rdata = converter_config;
            arc_pkg::OFS_PIN_DISABLE: next_rdata = analog_pin_disable_low;
            arc_pkg::OFS_CMP_CTRL:
               next_rdata = {6'h0, compare_polarity, compare_enable};
            arc_pkg::OFS_STATUS:
               next_rdata = {5'h0, valid, frozen, complete};
            default:                  next_rdata = 8'h00;
         endcase
      end
      // hardware side: a completion wins over a same-cycle clear
      if (accept) begin
         if (wide) begin
            next_result_low = conv_data_i[7:0];
            next_result_top = conv_data_i[9:8];
         end else begin
            next_result_low = conv_data_i[7:0];
            next_result_top = 2'h0;
         end
         next_complete = 1'b1;
         next_valid    = 1'b1;
      end
   end

   // registers only capture the next values
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         result_low             <= arc_pkg::RST_BYTE;
         result_top             <= 2'h0;
         compare_value_high     <= arc_pkg::RST_BYTE;
         compare_value_low      <= arc_pkg::RST_BYTE;
         converter_config       <= arc_pkg::RST_BYTE;
         analog_pin_disable_low <= arc_pkg::RST_BYTE;
         compare_enable         <= 1'b0;
         compare_polarity       <= 1'b0;
         complete               <= 1'b0;
         frozen                 <= 1'b0;
         valid                  <= 1'b0;
         rdata_o                <= arc_pkg::RST_BYTE;
      end else begin
         result_low             <= next_result_low;
         result_top             <= next_result_top;
         compare_value_high     <= next_compare_value_high;
         compare_value_low      <= next_compare_value_low;
         converter_config       <= next_converter_config;
         analog_pin_disable_low <= next_analog_pin_disable_low;
         compare_enable         <= next_compare_enable;
         compare_polarity       <= next_compare_polarity;
         complete               <= next_complete;
         frozen                 <= next_frozen;
         valid                  <= next_valid;
         rdata_o                <= next_rdata;
      end
   end

   // ************************************************************
   // configuration outputs and converter clock
   // ************************************************************
   assign low_power_o   = converter_config[arc_pkg::CFG_LOW_POWER_BIT];
   assign clock_divide_o = converter_config[arc_pkg::CFG_DIV_LSB +: 2];
   assign long_sample_o = converter_config[arc_pkg::CFG_LONG_SMP_BIT];
   assign width_10bit_o = wide;
   assign input_clock_select_o =
      converter_config[arc_pkg::CFG_CLKSEL_LSB +: 2];
   assign complete_o    = complete;

   // source clocks act as enables so the whole block stays in one domain;
   // limitation: alternate and internal sources are sampled on clock_i,
   // so they must run well below it or edges are lost
   // the divider counts source ticks, not bus cycles, so the ratio holds
   // whatever source is picked; the output toggles once per divided tick
   logic [2:0] div_cnt, next_div_cnt;
   logic       conv_clk, next_conv_clk;
   logic       src_tick, src_prev, next_src_prev;
   logic       bus_half, next_bus_half;
   logic [2:0] last_count;
   always_comb begin
      next_src_prev = src_prev;
      // halved bus source: every second bus enable is passed on
      next_bus_half = bus_clock_i ? !bus_half : bus_half;
      case (input_clock_select_o)
         2'h0: src_tick = bus_clock_i;
         2'h1: src_tick = bus_clock_i && bus_half;
         2'h2: src_tick = alternate_clock_i && !src_prev;
         2'h3: src_tick = internal_async_clock_i && !src_prev;
         default: src_tick = 1'b0;
      endcase
      if (input_clock_select_o[1])
         next_src_prev = input_clock_select_o[0] ? internal_async_clock_i
                                                 : alternate_clock_i;
      // ratio 1, 2, 4 or 8 source ticks per output step
      last_count    = 3'((4'h1 << clock_divide_o) - 4'h1);
      next_div_cnt  = div_cnt;
      next_conv_clk = conv_clk;
      if (src_tick) begin
         // >= so a ratio lowered mid-count wraps at once
         if (div_cnt >= last_count) begin
            next_div_cnt  = 3'h0;
            next_conv_clk = !conv_clk;
         end else begin
            next_div_cnt  = div_cnt + 3'h1;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         div_cnt  <= 3'h0;
         conv_clk <= 1'b0;
         src_prev <= 1'b0;
         bus_half <= 1'b0;
      end else begin
         div_cnt  <= next_div_cnt;
         conv_clk <= next_conv_clk;
         src_prev <= next_src_prev;
         bus_half <= next_bus_half;
      end
   end
   assign converter_clock_o = conv_clk;

   // ************************************************************
   // pin control
   // ************************************************************
   // a disabled pin hands the pad to the analog input
   assign pin_out_o    = port_out_i & ~analog_pin_disable_low;
   assign pin_oe_o     = port_oe_i & ~analog_pin_disable_low;
   assign pin_pullup_o = port_pullup_i & ~analog_pin_disable_low;
   assign port_in_o    = pin_in_i & ~analog_pin_disable_low;

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_high_read;
      read_i && addr_i == arc_pkg::OFS_RESULT_HIGH && wide;
   endsequence
   chk_freeze_holds: assert property (@(posedge clock_i) disable iff (reset_i)
      s_high_read ##1 (frozen && done_i) |=> $stable(result_low))
      else $error("result changed while frozen");
   chk_freeze_set: assert property (@(posedge clock_i) disable iff (reset_i)
      read_i && addr_i == arc_pkg::OFS_RESULT_HIGH && wide && !write_i
      |=> frozen)
      else $error("high read did not freeze");
   // a low read with no completion beside it clears the flag
   sequence s_low_read;
      read_i && addr_i == arc_pkg::OFS_RESULT_LOW && !accept;
   endsequence
   chk_flag_clear: assert property (@(posedge clock_i) disable iff (reset_i)
      s_low_read |=> !complete)
      else $error("low read left complete flag set");
   // the divided clock only steps on a source tick at the end of a count
   sequence s_div_end;
      src_tick && div_cnt >= last_count;
   endsequence
   chk_div_step: assert property (@(posedge clock_i) disable iff (reset_i)
      s_div_end |=> conv_clk != $past(conv_clk))
      else $error("converter clock missed its step");
   chk_div_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      !src_tick |=> $stable(conv_clk))
      else $error("converter clock moved without a tick");
   chk_no_freeze8: assert property (@(posedge clock_i) disable iff (reset_i)
      !wide |=> !frozen || $past(write_i))
      else $error("freeze in 8-bit width");
   chk_load_low: assert property (@(posedge clock_i) disable iff (reset_i)
      accept |=> result_low == $past(conv_data_i[7:0]))
      else $error("result low not loaded");
   chk_cmp_gate: assert property (@(posedge clock_i) disable iff (reset_i)
      done_i && compare_enable && !cmp_true |=> $stable(result_low))
      else $error("failed compare loaded result");
   chk_flag_set: assert property (@(posedge clock_i) disable iff (reset_i)
      done_i && !frozen && !compare_enable |=> complete)
      else $error("complete flag not set");
   chk_high_zero: assert property (@(posedge clock_i) disable iff (reset_i)
      s_high_read or (read_i && addr_i == arc_pkg::OFS_RESULT_HIGH && !wide)
      |=> (wide || rdata_o == 8'h00))
      else $error("result high nonzero in 8-bit width");
   chk_width_inval: assert property (@(posedge clock_i) disable iff (reset_i)
      write_i && addr_i == arc_pkg::OFS_CONFIG && !done_i
      && wdata_i[3:2] != converter_config[3:2] |=> !valid)
      else $error("width change left result valid");
   chk_pin_off: assert property (@(posedge clock_i) disable iff (reset_i)
      (pin_oe_o & analog_pin_disable_low) == 8'h00
      && (port_in_o & analog_pin_disable_low) == 8'h00)
      else $error("disabled pin still driven");
endmodule

/* File: tb/arc_regs_bench.sv */
// testbench: random register, result, compare and pin checks of the block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end
module arc_regs_bench;
   localparam int LIMIT = 20000;
   logic       clock_i = 1'b0;
   logic       reset_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       write_i = 1'b0;
   logic       read_i = 1'b0;
   logic       done_i = 1'b0;
   logic [9:0] conv_data_i = 10'h000;
   logic       bus_clock_i = 1'b0;
   logic       alternate_clock_i = 1'b0;
   logic       internal_async_clock_i = 1'b0;
   logic [7:0] port_out_i = 8'h00;
   logic [7:0] port_oe_i = 8'h00;
   logic [7:0] port_pullup_i = 8'h00;
   logic [7:0] pin_in_i = 8'h00;
   logic [7:0] rdata_o, pin_out_o, pin_oe_o, pin_pullup_o, port_in_o;
   logic [1:0] clock_divide_o, input_clock_select_o;
   logic       low_power_o, long_sample_o, width_10bit_o;
   logic       complete_o, converter_clock_o;
   int         n_fail, comparisons, cycles;
   logic [7:0] cfg, cl, ch, dis, got;
   logic [9:0] m_res, res, cv, d;
   logic       w, en, pol, frz, valid, m_cc;

   arc_regs dut_u (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
      .rdata_o(rdata_o), .done_i(done_i), .conv_data_i(conv_data_i),
      .low_power_o(low_power_o), .clock_divide_o(clock_divide_o),
      .long_sample_o(long_sample_o), .width_10bit_o(width_10bit_o),
      .input_clock_select_o(input_clock_select_o),
      .complete_o(complete_o), .bus_clock_i(bus_clock_i),
      .alternate_clock_i(alternate_clock_i),
      .internal_async_clock_i(internal_async_clock_i),
      .converter_clock_o(converter_clock_o), .port_out_i(port_out_i),
      .port_oe_i(port_oe_i), .port_pullup_i(port_pullup_i),
      .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
      .pin_pullup_o(pin_pullup_o), .port_in_o(port_in_o));

   // ************************************************************
   // clock, clock sources and hang guard
   // ************************************************************
   always #20 clock_i = ~clock_i;
   // bus and internal sources wander at random, alternate toggles each cycle, so the divider path sees real edges
   always @(posedge clock_i) begin
      bus_clock_i <= 1'($urandom);
      alternate_clock_i <= ~alternate_clock_i;
      internal_async_clock_i <= 1'($urandom);
      cycles++;
      if (cycles > LIMIT) begin
         n_fail++;
         close_out();
      end
   end

   // ************************************************************
   // bus tasks and expectation helpers
   // ************************************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
      #1;
   endtask
   // read data are taken in the single cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask
   task automatic conv(input logic [9:0] v);
      @(posedge clock_i);
      conv_data_i <= v;
      done_i <= 1'b1;
      @(posedge clock_i);
      done_i <= 1'b0;
      #1;
   endtask
   function automatic logic cmp_hit(input logic [9:0] r, c, input logic p);
      return p ? (r >= c) : (r < c);
   endfunction

   // ************************************************************
   // main sequence: eight width/compare/polarity phases
   // ************************************************************
   initial begin
      void'($urandom(32'h2fe3a00b));
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      // indices 0 to 8, the first unmapped one too, read zero after reset
      for (int a = 0; a < 9; a++) begin
         rd(a[3:0], got);
         `CHK(got, 8'h00)
      end
      for (int i = 0; i < 8; i++) begin
         w = i[0];
         en = i[1];
         pol = i[2];
         cfg = 8'($urandom);
         cfg[6:5] = i[2:1];
         cfg[3:2] = w ? arc_pkg::WIDTH_10 : arc_pkg::WIDTH_8;
         cfg[1:0] = ~i[1:0];
         cl = 8'($urandom);
         ch = 8'($urandom);
         dis = 8'($urandom);
         wr(arc_pkg::OFS_CONFIG, cfg);
         wr(arc_pkg::OFS_CMP_LOW, cl);
         wr(arc_pkg::OFS_CMP_HIGH, ch);
         wr(arc_pkg::OFS_CMP_CTRL, {6'h00, pol, en});
         wr(arc_pkg::OFS_PIN_DISABLE, dis);
         wr(4'h9, 8'hff);
         @(posedge clock_i);
         port_out_i <= 8'($urandom);
         port_oe_i <= 8'($urandom);
         port_pullup_i <= 8'($urandom);
         pin_in_i <= 8'($urandom);
         // a low read clears the flag and any pending freeze
         rd(arc_pkg::OFS_RESULT_LOW, got);
         frz = 1'b0;
         m_cc = 1'b0;
         valid = 1'b0;
         rd(arc_pkg::OFS_STATUS, got);
         `CHK(got[arc_pkg::STS_VALID_BIT], 1'b0)
         rd(arc_pkg::OFS_CONFIG, got);
         `CHK(got, cfg)
         rd(arc_pkg::OFS_CMP_LOW, got);
         `CHK(got, cl)
         rd(arc_pkg::OFS_CMP_HIGH, got);
         `CHK(got[1:0], ch[1:0])
         rd(arc_pkg::OFS_PIN_DISABLE, got);
         `CHK(got, dis)
         rd(4'h9, got);
         `CHK(got, 8'h00)
         `CHK(low_power_o, cfg[7])
         `CHK(clock_divide_o, cfg[6:5])
         `CHK(long_sample_o, cfg[4])
         `CHK(width_10bit_o, w)
         `CHK(input_clock_select_o, cfg[1:0])
         `CHK(pin_oe_o, port_oe_i & ~dis)
         `CHK(pin_pullup_o, port_pullup_i & ~dis)
         `CHK(port_in_o, pin_in_i & ~dis)
         `CHK(pin_out_o & ~dis, port_out_i & ~dis)
         // random mix of completions and reads in either order
         repeat (40) begin
            case ($urandom_range(2, 0))
               0: begin
                  d = 10'($urandom);
                  conv(d);
                  res = w ? d : {2'b00, d[7:0]};
                  cv = w ? {ch[1:0], cl} : {2'b00, cl};
                  if (!(w && frz) && (!en || cmp_hit(res, cv, pol))) begin
                     m_res = res;
                     valid = 1'b1;
                     m_cc = 1'b1;
                  end
               end
               1: begin
                  rd(arc_pkg::OFS_RESULT_HIGH, got);
                  if (!w) `CHK(got, 8'h00)
                  else if (valid) `CHK(got, {6'h00, m_res[9:8]})
                  frz = w;
               end
               default: begin
                  rd(arc_pkg::OFS_RESULT_LOW, got);
                  if (valid) `CHK(got, m_res[7:0])
                  frz = 1'b0;
                  m_cc = 1'b0;
               end
            endcase
            `CHK(complete_o, m_cc)
         end
      end
      close_out();
   end
endmodule
